// File: verilog/midi_scene_mute_control.sv
// Purpose: Scene recall and channel mute control over the music link.
// Assumes: APB master for software; remote pins asynchronous to clk.
// Notes: Panel keys arrive as writes to the command register.
`timescale 1ns/100ps
module midi_scene_mute_control
	import midi_scene_pkg::*;
#(
	parameter int CH = MUTE_CHANNELS,
	parameter int BIT_CNT = BIT_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic midiIn,
	output logic midiOut,
	input wire logic remoteUp,
	input wire logic remoteDown,
	output logic [CH-1:0] mutes
);
	midi_byte_if link();
	logic [4:0] txChan_r;
	logic [4:0] rxChan_r;
	logic noteMuteEn_r;
	view_e view_r;
	logic [6:0] scene_r;
	logic [CH-1:0] mutes_r;
	logic [CH-1:0] sceneMem_r [SCENES];
	logic [6:0] memIdx_r;
	logic [7:0] status_r;
	logic [6:0] data1_r;
	logic haveData1_r;
	logic [1:0][2:0] remSync_r;
	logic [1:0] remLevel_r;
	logic [7:0] txBuf_r [6];
	logic [2:0] txLen_r;
	logic [2:0] txIdx_r;
	logic wrEn;
	logic rdEn;
	logic progHit;
	logic noteHit;
	logic [6:0] noteIdx;
	logic [1:0] remPress;
	logic cmdRecall;
	logic keyDo;
	logic [4:0] keyCh;
	logic recallDo;
	logic [6:0] recallNum;
	logic txBusy;
	logic [31:0] rdMux;

	// All checks below run on the system clock and pause during reset.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// True when a message channel passes the receive channel setting.
	function automatic logic chanMatch(input logic [4:0] sel,
		input logic [3:0] ch);
		chanMatch = (sel == RX_OMNI) || (sel == {1'b0, ch});
	endfunction

	// Next scene number one step up or down, wrapping inside the store.
	function automatic logic [6:0] stepScene(input logic [6:0] s,
		input logic up);
		if (up) begin
			stepScene = (s >= SCENE_MAX) ? 7'h00 : s + 7'h01;
		end else begin
			stepScene = (s == 7'h00) ? SCENE_MAX : s - 7'h01;
		end
	endfunction

	midi_serial_port #(.BIT_CNT(BIT_CNT)) serialPort (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.midiIn(midiIn),
		.midiOut(midiOut),
		.bus(link.port)
	);

	// APB decode; the slave always answers in the access cycle.
	assign pready = 1'b1;
	assign wrEn = ce && psel && penable && pwrite;
	assign rdEn = psel && !pwrite;
	assign mutes = mutes_r;
	assign txBusy = (txIdx_r != txLen_r);
	assign link.txValid = txBusy;
	// The index never reaches the buffer end while a byte is offered.
	assign link.txData = txBusy ? txBuf_r[txIdx_r] : 8'h00;

	// Unmapped addresses read zero and flag an error.
	always_comb begin
		rdMux = 32'h0000_0000;
		pslverr = 1'b0;
		if (paddr == OFF_CTRL) begin
			rdMux[CTRL_TX_LSB +: 5] = txChan_r;
			rdMux[CTRL_RX_LSB +: 5] = rxChan_r;
			rdMux[CTRL_NME_BIT] = noteMuteEn_r;
			rdMux[CTRL_VIEW_LSB +: 2] = view_r;
		end else if (paddr == OFF_CMD) begin
			rdMux[STAT_BUSY_BIT] = txBusy;
		end else if (paddr == OFF_STAT) begin
			rdMux[6:0] = scene_r;
			rdMux[STAT_BUSY_BIT] = txBusy;
		end else if (paddr == OFF_MUTE) begin
			rdMux[CH-1:0] = mutes_r;
		end else if (paddr == OFF_MIDX) begin
			rdMux[6:0] = memIdx_r;
		end else if (paddr == OFF_MDAT) begin
			rdMux[CH-1:0] = sceneMem_r[memIdx_r];
		end else begin
			pslverr = psel && penable;
		end
	end

	// Read data is captured in the setup cycle and held through access.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
		end else if (ce) begin
			if (!rdEn) begin
				prdata <= 32'h0000_0000;
			end else if (!penable) begin
				prdata <= rdMux;
			end
		end
	end

	// Channel settings, view and note-mute enable.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			txChan_r <= TX_RST;
			rxChan_r <= RX_RST;
			noteMuteEn_r <= NME_RST;
			view_r <= VIEW_SCENE;
		end else if (wrEn && paddr == OFF_CTRL) begin
			if (pwdata[CTRL_TX_LSB +: 5] <= TX_OFF) begin
				txChan_r <= pwdata[CTRL_TX_LSB +: 5];
			end
			if (pwdata[CTRL_RX_LSB +: 5] <= RX_OFF) begin
				rxChan_r <= pwdata[CTRL_RX_LSB +: 5];
			end
			if (pwdata[CTRL_VIEW_LSB +: 2] != 2'h3) begin
				view_r <= view_e'(pwdata[CTRL_VIEW_LSB +: 2]);
			end
		end else if (wrEn && paddr == OFF_CMD && pwdata[CMD_TOGGLE_BIT]
			&& view_r != VIEW_SCENE) begin
			noteMuteEn_r <= !noteMuteEn_r;
		end
	end

	// Remote footswitch pins: three stages, level moves when two agree.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			remSync_r <= '0;
			remLevel_r <= 2'h0;
		end else if (ce) begin
			remSync_r[0] <= {remSync_r[0][1:0], remoteUp};
			remSync_r[1] <= {remSync_r[1][1:0], remoteDown};
			for (int i = 0; i < 2; i++) begin
				if (remSync_r[i][1] == remSync_r[i][2]) begin
					remLevel_r[i] <= remSync_r[i][2];
				end
			end
		end
	end
	assign remPress[0] = remSync_r[0][1] && remSync_r[0][2] && !remLevel_r[0];
	assign remPress[1] = remSync_r[1][1] && remSync_r[1][2] && !remLevel_r[1];

	// Incoming message decode with running status.
	// off ignores all, channel match
	assign progHit = link.rxValid && !link.rxData[7] && rxChan_r != RX_OFF
		&& status_r[7:4] == ST_PROG && chanMatch(rxChan_r, status_r[3:0]);
	assign noteIdx = link.rxData[6:0] == 7'h00 ? 7'h7f : data1_r - NOTE_BASE;
	// enable gate, note range, velocity zero ignored
	assign noteHit = link.rxValid && !link.rxData[7] && haveData1_r
		&& rxChan_r != RX_OFF && noteMuteEn_r
		&& status_r[7:4] == ST_NOTE_ON && chanMatch(rxChan_r, status_r[3:0])
		&& data1_r >= NOTE_BASE && noteIdx < 7'(CH);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			status_r <= 8'h00;
			data1_r <= 7'h00;
			haveData1_r <= 1'b0;
		end else if (ce && link.rxValid) begin
			if (link.rxData[7]) begin
				if (link.rxData < 8'hf8) begin
					status_r <= link.rxData;
					haveData1_r <= 1'b0;
				end
			end else if (status_r[7:4] == ST_NOTE_ON) begin
				data1_r <= link.rxData[6:0];
				haveData1_r <= !haveData1_r;
			end
		end
	end

	// Recall sources in priority: received, command, remote up, down.
	assign cmdRecall = wrEn && paddr == OFF_CMD && pwdata[CMD_RECALL_BIT];
	assign keyCh = pwdata[CMD_CH_LSB +: 5];
	assign keyDo = wrEn && paddr == OFF_CMD && pwdata[CMD_KEY_BIT]
		&& keyCh < 5'(CH);
	always_comb begin
		recallDo = 1'b0;
		recallNum = scene_r;
		if (progHit) begin
			recallDo = 1'b1;
			recallNum = link.rxData[6:0];
		end else if (cmdRecall) begin
			recallDo = 1'b1;
			recallNum = pwdata[6:0];
		end else if (wrEn && paddr == OFF_CMD && pwdata[CMD_UP_BIT]) begin
			recallDo = 1'b1;
			recallNum = stepScene(scene_r, 1'b1);
		end else if (wrEn && paddr == OFF_CMD && pwdata[CMD_DOWN_BIT]) begin
			recallDo = 1'b1;
			recallNum = stepScene(scene_r, 1'b0);
		end else if (ce && remPress[0]) begin
			recallDo = 1'b1;
			recallNum = stepScene(scene_r, 1'b1);
		end else if (ce && remPress[1]) begin
			recallDo = 1'b1;
			recallNum = stepScene(scene_r, 1'b0);
		end
		if (recallNum > SCENE_MAX) begin
			recallDo = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			memIdx_r <= 7'h00;
		end else if (wrEn && paddr == OFF_MIDX) begin
			memIdx_r <= (pwdata[6:0] > SCENE_MAX) ? SCENE_MAX : pwdata[6:0];
		end
	end
	always_ff @(posedge clk) begin
		if (wrEn && paddr == OFF_MDAT) begin
			sceneMem_r[memIdx_r] <= pwdata[CH-1:0];
		end
	end

	// Scene number and live mutes.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			scene_r <= 7'h00;
			mutes_r <= '0;
		end else if (ce) begin
			if (recallDo) begin
				scene_r <= recallNum;
				mutes_r <= sceneMem_r[recallNum];
			end else if (noteHit) begin
				mutes_r[noteIdx[4:0]] <= (link.rxData[6:0] >= VEL_ON);
			end else if (keyDo) begin
				mutes_r[keyCh] <= !mutes_r[keyCh];
			end else if (wrEn && paddr == OFF_MUTE) begin
				mutes_r <= pwdata[CH-1:0];
			end
		end
	end

	// Outgoing message builder; a request while busy is not sent.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			txLen_r <= 3'h0;
			txIdx_r <= 3'h0;
			for (int i = 0; i < 6; i++) begin
				txBuf_r[i] <= 8'h00;
			end
		end else if (ce) begin
			if (!txBusy && txChan_r != TX_OFF && recallDo) begin
				txBuf_r[0] <= {ST_PROG, txChan_r[3:0]};
				txBuf_r[1] <= {1'b0, recallNum};
				txLen_r <= 3'h2;
				txIdx_r <= 3'h0;
			end else if (!txBusy && txChan_r != TX_OFF && keyDo) begin
				txBuf_r[0] <= {ST_NOTE_ON, txChan_r[3:0]};
				txBuf_r[1] <= {1'b0, NOTE_BASE + 7'(keyCh)};
				txBuf_r[2] <= {1'b0, VEL_KEY};
				txBuf_r[3] <= {ST_NOTE_ON, txChan_r[3:0]};
				txBuf_r[4] <= {1'b0, NOTE_BASE + 7'(keyCh)};
				txBuf_r[5] <= 8'h00;
				txLen_r <= 3'h6;
				txIdx_r <= 3'h0;
			end else if (txBusy && link.txReady) begin
				txIdx_r <= txIdx_r + 3'h1;
			end
		end
	end

	chk_recall_range: assert property (ce && progHit
		&& link.rxData[6:0] <= SCENE_MAX |-> recallDo)
		else $error("In-range program change was not recalled.");
	chk_recall_loads: assert property (ce && recallDo |=>
		scene_r == $past(recallNum) && mutes_r == $past(sceneMem_r[recallNum]))
		else $error("Recall did not load the scene.");
	chk_prog_reject: assert property (ce && progHit && link.rxData[6:0] >
		SCENE_MAX |=> $stable(scene_r))
		else $error("Out-of-range program change moved the scene.");
	chk_rx_off: assert property (rxChan_r == RX_OFF |->
		!progHit && !noteHit)
		else $error("Message taken with receive off.");
	chk_note_gate: assert property (!noteMuteEn_r |-> !noteHit)
		else $error("Note acted with note muting off.");
	chk_note_sets: assert property (ce && noteHit && !recallDo |=>
		mutes_r[$past(noteIdx[4:0])] == ($past(link.rxData[6:0]) >= VEL_ON))
		else $error("Note velocity did not set the mute.");
	chk_prog_sends: assert property (ce && recallDo && !txBusy
		&& txChan_r != TX_OFF |=> txBusy && txLen_r == 3'h2
		&& txBuf_r[0] == {ST_PROG, $past(txChan_r[3:0])}
		&& txBuf_r[1] == {1'b0, $past(recallNum)})
		else $error("Recall did not queue a program change.");
	chk_key_pair: assert property (ce && keyDo && !recallDo && !txBusy
		&& txChan_r != TX_OFF |=> txLen_r == 3'h6
		&& txBuf_r[2] == {1'b0, VEL_KEY} && txBuf_r[5] == 8'h00
		&& txBuf_r[1] == txBuf_r[4])
		else $error("Mute key did not queue a note pair.");
	chk_chan_range: assert property (txChan_r <= TX_OFF
		&& rxChan_r <= RX_OFF)
		else $error("Channel setting out of range.");

	cov_rx_recall: cover property (ce && progHit && recallDo);
	cov_note_mute: cover property (ce && noteHit);
	cov_key_send: cover property (ce && keyDo ##1 txBusy);
	cov_remote: cover property (ce && remPress[0] && recallDo);
endmodule // midi_scene_mute_control

// File: verilog/midi_scene_pkg.sv
// Purpose: Shared constants for the scene and mute control over the music link.
// Assumes: 100 MHz system clock, standard serial music rate of 31250 baud.
// Notes: Register offsets are byte addresses on a 32-bit APB slave.
package midi_scene_pkg;
	// Clock and link timing.
	localparam int CLK_HZ = 100_000_000;
	localparam int MIDI_BAUD = 31250;
	localparam int BIT_CYCLES = CLK_HZ / MIDI_BAUD;
	// Scene store and channel limits.
	localparam int SCENES = 99;
	localparam logic [6:0] SCENE_MAX = 7'h62;
	localparam int MUTE_CHANNELS = 18;
	localparam logic [4:0] TX_OFF = 5'h10;
	localparam logic [4:0] RX_OMNI = 5'h10;
	localparam logic [4:0] RX_OFF = 5'h11;
	// Register byte offsets.
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_CMD = 8'h04;
	localparam logic [7:0] OFF_STAT = 8'h08;
	localparam logic [7:0] OFF_MUTE = 8'h0c;
	localparam logic [7:0] OFF_MIDX = 8'h10;
	localparam logic [7:0] OFF_MDAT = 8'h14;
	// Field positions.
	localparam int CTRL_TX_LSB = 0;
	localparam int CTRL_RX_LSB = 8;
	localparam int CTRL_NME_BIT = 16;
	localparam int CTRL_VIEW_LSB = 17;
	localparam int CMD_RECALL_BIT = 8;
	localparam int CMD_KEY_BIT = 9;
	localparam int CMD_TOGGLE_BIT = 10;
	localparam int CMD_UP_BIT = 11;
	localparam int CMD_DOWN_BIT = 12;
	localparam int CMD_CH_LSB = 16;
	localparam int STAT_BUSY_BIT = 8;
	// Reset values.
	localparam logic [4:0] TX_RST = 5'h00;
	localparam logic [4:0] RX_RST = 5'h00;
	localparam logic NME_RST = 1'b0;
	// Message codes and note mapping.
	localparam logic [3:0] ST_PROG = 4'hc;
	localparam logic [3:0] ST_NOTE_ON = 4'h9;
	localparam logic [6:0] NOTE_BASE = 7'h24;
	localparam logic [6:0] VEL_ON = 7'h40;
	localparam logic [6:0] VEL_KEY = 7'h7f;
	// Display view selected through the control register view field.
	typedef enum logic [1:0] {VIEW_SCENE, VIEW_SEND, VIEW_RCV} view_e;
endpackage

// File: verilog/midi_byte_if.sv
// Purpose: Byte stream between the scene controller and the serial port.
// Assumes: One clock; a transmit byte is taken when txValid and txReady.
// Notes: rxValid is a one-cycle pulse per received byte.
`timescale 1ns/100ps
interface midi_byte_if;
	logic [7:0] txData;
	logic txValid;
	logic txReady;
	logic [7:0] rxData;
	logic rxValid;
	modport port(input txData, input txValid, output txReady,
		output rxData, output rxValid);
	modport core(output txData, output txValid, input txReady,
		input rxData, input rxValid);
endinterface

// File: verilog/midi_serial_port.sv
// Purpose: Serial byte transmitter and receiver for the music link.
// Assumes: 8 data bits, one start and one stop bit, no parity.
// Notes: The receive pin is synchronised by three flip-flops.
`timescale 1ns/100ps
module midi_serial_port
	import midi_scene_pkg::*;
#(
	parameter int BIT_CNT = BIT_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic midiIn,
	output logic midiOut,
	midi_byte_if.port bus
);
	logic [8:0] txShift_r;
	logic [3:0] txLeft_r;
	logic [15:0] txCnt_r;
	logic [2:0] rxSync_r;
	logic rxLine_r;
	logic [3:0] rxBits_r;
	logic [15:0] rxCnt_r;
	logic [7:0] rxShift_r;
	logic [7:0] rxData_r;
	logic rxValid_r;

	assign bus.txReady = (txLeft_r == 4'h0);
	assign bus.rxData = rxData_r;
	assign bus.rxValid = rxValid_r;

	// Transmitter: start bit, data LSB first, stop bit, each BIT_CNT long.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			txShift_r <= 9'h1ff;
			txLeft_r <= 4'h0;
			txCnt_r <= 16'h0000;
			midiOut <= 1'b1;
		end else if (ce) begin
			if (txLeft_r == 4'h0) begin
				if (bus.txValid) begin
					midiOut <= 1'b0;
					txShift_r <= {1'b1, bus.txData};
					txLeft_r <= 4'ha;
					txCnt_r <= 16'(BIT_CNT - 1);
				end
			end else if (txCnt_r != 16'h0000) begin
				txCnt_r <= txCnt_r - 16'h0001;
			end else begin
				txLeft_r <= txLeft_r - 4'h1;
				txCnt_r <= 16'(BIT_CNT - 1);
				if (txLeft_r > 4'h1) begin
					midiOut <= txShift_r[0];
					txShift_r <= {1'b1, txShift_r[8:1]};
				end
			end
		end
	end

	// Three-stage synchroniser; the line level moves when stages two and
	// three agree, which filters single-cycle glitches.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rxSync_r <= 3'h7;
			rxLine_r <= 1'b1;
		end else if (ce) begin
			rxSync_r <= {rxSync_r[1:0], midiIn};
			if (rxSync_r[1] == rxSync_r[2]) begin
				rxLine_r <= rxSync_r[2];
			end
		end
	end

	// Receiver samples mid-bit; a frame without a high stop bit is dropped.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rxBits_r <= 4'h0;
			rxCnt_r <= 16'h0000;
			rxShift_r <= 8'h00;
			rxData_r <= 8'h00;
			rxValid_r <= 1'b0;
		end else if (ce) begin
			rxValid_r <= 1'b0;
			if (rxBits_r == 4'h0) begin
				if (!rxLine_r) begin
					rxBits_r <= 4'ha;
					rxCnt_r <= 16'(BIT_CNT / 2 - 1);
				end
			end else if (rxCnt_r != 16'h0000) begin
				rxCnt_r <= rxCnt_r - 16'h0001;
			end else begin
				rxCnt_r <= 16'(BIT_CNT - 1);
				if (rxBits_r == 4'ha) begin
					rxBits_r <= rxLine_r ? 4'h0 : 4'h9;
				end else if (rxBits_r == 4'h1) begin
					rxBits_r <= 4'h0;
					rxValid_r <= rxLine_r;
					rxData_r <= rxShift_r;
				end else begin
					rxShift_r <= {rxLine_r, rxShift_r[7:1]};
					rxBits_r <= rxBits_r - 4'h1;
				end
			end
		end
	end
endmodule // midi_serial_port

// File: tb/midi_peer.sv
// Purpose: Far-end instrument on the serial music link.
// Assumes: 8N1 frames; a bit lasts BIT_CNT clock cycles.
// Notes: Bytes heard from the design queue up in rxq.
`timescale 1ns/100ps
module midi_peer #(
	parameter int BIT_CNT = 16
) (
	input wire logic clk,
	input wire logic midiOut,
	output logic midiIn
);
	byte unsigned rxq[$];
	logic [7:0] shift;
	// The link idles high between frames.
	initial begin
		midiIn = 1'b1;
	end
	// Sends one frame: start bit, data bits LSB first, stop bit.
	task automatic sendByte(input logic [7:0] b);
		logic [9:0] frame;
		frame = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			midiIn <= frame[i];
			repeat (BIT_CNT - 1) @(posedge clk);
		end
	endtask
	task automatic sendProg(input logic [3:0] ch, input logic [6:0] num);
		sendByte({4'hc, ch});
		sendByte({1'b0, num});
	endtask
	// Sends a full note-on message with its status byte.
	task automatic sendNote(input logic [3:0] ch, input logic [6:0] nt,
		input logic [6:0] vel);
		sendByte({4'h9, ch});
		sendByte({1'b0, nt});
		sendByte({1'b0, vel});
	endtask
	// Samples each design bit mid-bit; a bad stop bit drops the byte.
	always begin
		@(negedge midiOut);
		repeat (BIT_CNT / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CNT) @(posedge clk);
			shift[i] = midiOut;
		end
		repeat (BIT_CNT) @(posedge clk);
		if (midiOut === 1'b1) begin
			rxq.push_back(shift);
		end
	end
endmodule // midi_peer

// File: tb/tb.sv
// Purpose: Self-checking bench for the scene and mute controller.
// Assumes: Short bit time of 16 cycles; APB master with bounded waits.
// Notes: The peer model plays the keyboard on the serial link.
`timescale 1ns/100ps
module tb;
	import midi_scene_pkg::*;
	localparam int BITS = 16;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0, prdata, rdv;
	logic pready, pslverr, midiIn, midiOut, errv;
	logic remoteUp = 1'b0, remoteDown = 1'b0;
	logic [17:0] mutes;
	int nMismatch = 0, checkCount = 0;
	logic [6:0] nn[7] = '{7'h24, 7'h35, 7'h24, 7'h23, 7'h36, 7'h35, 7'h25};
	logic [6:0] nv[7] = '{7'h7f, 7'h40, 7'h3f, 7'h7f, 7'h7f, 7'h00, 7'h7f};
	logic [3:0] nc[7] = '{4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'h5};
	logic [31:0] ne[7] = '{32'h1, 32'h20001, 32'h20000, 32'h20000,
		32'h20000, 32'h20000, 32'h20000};
	logic [7:0] kb[6] = '{8'h92, 8'h28, 8'h7f, 8'h92, 8'h28, 8'h00};
	midi_scene_mute_control #(.BIT_CNT(BITS)) dut_u (.clk(clk),
		.rst_n(rst_n), .ce(ce), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.midiIn(midiIn), .midiOut(midiOut), .remoteUp(remoteUp),
		.remoteDown(remoteDown), .mutes(mutes));
	midi_peer #(.BIT_CNT(BITS)) peer_u (.clk(clk), .midiOut(midiOut),
		.midiIn(midiIn));
	// Free-running 100 MHz clock.
	initial begin
		forever #5 clk = ~clk;
	end
	// Prints the verdict and stops the run.
	task automatic completeRun();
		if (nMismatch == 0 && checkCount > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Compares one value and reports a mismatch at once.
	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checkCount++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			nMismatch++;
		end
	endtask
	// One APB transfer; held until pready is seen high at an edge.
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			n++;
			if (n > 50) begin
				check("pready", 32'h1, 32'h0);
				completeRun();
			end
			@(posedge clk);
		end
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check($sformatf("register %h", a), exp, rdv);
		if (a == OFF_MUTE) begin
			check("mutes pin", exp, {14'h0, mutes});
		end
	endtask
	// Waits, bounded, for the next byte heard by the peer.
	task automatic expTx(input logic [7:0] b);
		int n;
		n = 0;
		while (peer_u.rxq.size() == 0 && n < 4000) begin
			@(posedge clk);
			n++;
		end
		if (peer_u.rxq.size() == 0) begin
			check("serial byte", {24'h0, b}, 32'hffffffff);
			completeRun();
		end
		check("serial byte", {24'h0, b}, {24'h0, peer_u.rxq.pop_front()});
	endtask
	// Confirms that the design sent nothing for a while.
	task automatic expQuiet();
		repeat (400) @(posedge clk);
		check("bytes sent", 32'h0, 32'(peer_u.rxq.size()));
	endtask
	// Sends a program change and lets the design act on it.
	task automatic prog(input logic [3:0] ch, input logic [6:0] num);
		peer_u.sendProg(ch, num);
		repeat (8) @(posedge clk);
	endtask
	// Presses a footswitch pin long enough to pass its synchroniser.
	task automatic press(input logic up);
		if (up) remoteUp <= 1'b1;
		else remoteDown <= 1'b1;
		repeat (20) @(posedge clk);
		remoteUp <= 1'b0;
		remoteDown <= 1'b0;
	endtask
	// Main sequence of scenarios.
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rd(OFF_CTRL, 32'h0);
		rd(OFF_MUTE, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		check("unmapped error", 32'h1, {31'h0, errv});
		wr(OFF_MIDX, 32'h0);
		wr(OFF_MDAT, 32'h0);
		wr(OFF_MIDX, 32'h5);
		wr(OFF_MDAT, 32'h2a5a5);
		wr(OFF_MIDX, 32'h7f);
		rd(OFF_MIDX, 32'h62);
		wr(OFF_MDAT, 32'h15a5a);
		rd(OFF_MDAT, 32'h15a5a);
		wr(OFF_CTRL, 32'h302);
		wr(OFF_CTRL, 32'h1211);
		rd(OFF_CTRL, 32'h302);
		// A write while the clock enable is low must not land.
		ce <= 1'b0;
		wr(OFF_CTRL, 32'h0);
		ce <= 1'b1;
		rd(OFF_CTRL, 32'h302);
		wr(OFF_CMD, 32'h105);
		rd(OFF_MUTE, 32'h2a5a5);
		expTx(8'hc2);
		expTx(8'h05);
		expQuiet();
		rd(OFF_STAT, 32'h5);
		prog(4'h3, SCENE_MAX);
		rd(OFF_MUTE, 32'h15a5a);
		expTx(8'hc2);
		expTx(8'h62);
		prog(4'h3, 7'h63);
		expQuiet();
		rd(OFF_STAT, 32'h62);
		prog(4'h4, 7'h05);
		rd(OFF_MUTE, 32'h15a5a);
		wr(OFF_CTRL, 32'h1002);
		prog(4'h9, 7'h00);
		rd(OFF_MUTE, 32'h0);
		expTx(8'hc2);
		expTx(8'h00);
		wr(OFF_CTRL, 32'h1102);
		prog(4'h3, 7'h05);
		expQuiet();
		rd(OFF_STAT, 32'h0);
		press(1'b0);
		expTx(8'hc2);
		expTx(8'h62);
		rd(OFF_MUTE, 32'h15a5a);
		press(1'b1);
		expTx(8'hc2);
		expTx(8'h00);
		wr(OFF_CTRL, 32'h302);
		peer_u.sendNote(4'h3, 7'h24, 7'h7f);
		repeat (8) @(posedge clk);
		rd(OFF_MUTE, 32'h0);
		wr(OFF_CMD, 32'h400);
		rd(OFF_CTRL, 32'h302);
		wr(OFF_CTRL, 32'h20302);
		wr(OFF_CMD, 32'h400);
		rd(OFF_CTRL, 32'h30302);
		for (int i = 0; i < 7; i++) begin
			peer_u.sendNote(nc[i], nn[i], nv[i]);
			repeat (8) @(posedge clk);
			rd(OFF_MUTE, ne[i]);
		end
		wr(OFF_CMD, 32'h40200);
		rd(OFF_MUTE, 32'h20010);
		for (int i = 0; i < 6; i++) begin
			expTx(kb[i]);
		end
		// Panel step keys recall and announce the new scene.
		wr(OFF_CMD, 32'h1000);
		rd(OFF_MUTE, 32'h15a5a);
		expTx(8'hc2);
		expTx(8'h62);
		wr(OFF_CMD, 32'h800);
		rd(OFF_MUTE, 32'h0);
		expTx(8'hc2);
		expTx(8'h00);
		wr(OFF_CTRL, 32'h20310);
		wr(OFF_CMD, 32'h105);
		rd(OFF_MUTE, 32'h2a5a5);
		expQuiet();
		// A reset in mid-run brings settings and mutes back to idle.
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(OFF_CTRL, 32'h0);
		rd(OFF_MUTE, 32'h0);
		completeRun();
	end
endmodule // tb
